// >>> inc/brc_pkg.sv
// Shared constants, field layout and state types for the board reset logic
package brc_pkg;

  // Board logic clock and derived timing
  localparam int CLK_HZ = 10_000_000;
  localparam int DEBOUNCE_US = 10_000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  // Least hold of a board-driven reset, in processor clocks
  localparam int MIN_HOLD_CYC = 512;
  localparam int HOLD_W = 10;

  // Register byte offsets on the bus
  localparam logic [3:0] REG_CFG_NEXT = 4'h0;
  localparam logic [3:0] REG_CFG_ACT = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // Configuration word field positions
  localparam int CFG_ARB_BIT = 0;
  localparam int CFG_IPREFIX_BIT = 1;
  localparam int CFG_BOOT_DIS_BIT = 2;
  localparam int CFG_BPS_LSB = 3;
  localparam int CFG_ISB_LSB = 5;
  localparam int CFG_DBG_PINS_LSB = 7;
  localparam int CFG_DBG_PORT_BIT = 9;
  localparam int CFG_EBDF_LSB = 10;
  // Internal arb, prefix at 0, boot on, 32-bit port, base at FF00000,
  // debug pins as PCMCIA B, debug port on JTAG, 1:1 bus ratio
  localparam logic [15:0] CFG_DEFAULT = 16'h0001 << CFG_DBG_PORT_BIT;

  // Status register bit positions
  localparam int STS_STATE_LSB = 0;
  localparam int STS_HARD_BIT = 2;
  localparam int STS_SOFT_BIT = 3;
  localparam int STS_POR_BIT = 4;
  localparam int STS_DIP_BIT = 5;
  localparam int STS_PROC_BIT = 6;

  // Positions in the pin synchroniser vector
  localparam int PIN_POR_N = 0;
  localparam int PIN_DIP = 1;
  localparam int PIN_PROC = 2;
  localparam int PIN_HARD_N = 3;
  localparam int PIN_SOFT_N = 4;
  localparam int PIN_W = 5;
  // Synchroniser contents after reset: power-on still seen active, so
  // the hard line stays driven until the real pin levels arrive
  localparam logic [PIN_W-1:0] PIN_IDLE = 5'h1c;

  // Clock-mode pin values during power-on reset
  localparam logic [1:0] MODCK_PLL5 = 2'h3;
  localparam logic [1:0] MODCK_PLL513 = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SOFT = 2'h1,
    ST_HARD = 2'h3,
    ST_WAIT = 2'h2
  } brc_state_t;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    brc_state_t st;
    logic [HOLD_W-1:0] cnt;
    logic [15:0] cfg_next;
    logic [15:0] cfg_act;
    logic in_hard;
    logic ack;
    logic [31:0] rdat;
    logic od_lvl;
    logic hard_oe_n;
    logic soft_oe_n;
    logic irq_oe_n;
    logic [1:0] modck;
    logic modck_oe_n;
    logic conf_n;
    logic dat_oe_n;
    logic gate;
    logic clk_sel;
  } brc_regs_t;

  localparam brc_regs_t BRC_REGS_RST = '{
    s1: PIN_IDLE, s2: PIN_IDLE, st: ST_IDLE, cnt: '0,
    cfg_next: CFG_DEFAULT, cfg_act: CFG_DEFAULT,
    in_hard: 1'b1, ack: 1'b0, rdat: '0, od_lvl: 1'b0,
    hard_oe_n: 1'b0, soft_oe_n: 1'b1, irq_oe_n: 1'b1,
    modck: MODCK_PLL5, modck_oe_n: 1'b0, conf_n: 1'b0,
    dat_oe_n: 1'b0, gate: 1'b1, clk_sel: 1'b1};

endpackage : brc_pkg

// >>> core/brc_debounce.sv
// Push-button synchroniser and debouncer
module brc_debounce
  import brc_pkg::*;
#(
  parameter int CNT_MAX = DEBOUNCE_CYC
)(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic button_n_in,
  output logic pressed_out
);

  localparam int CW = $clog2(CNT_MAX + 1);

  typedef struct packed {
    logic s1;
    logic s2;
    logic pressed;
    logic [CW-1:0] cnt;
  } brc_deb_t;

  brc_deb_t r_q;
  brc_deb_t r_d;

  // Zero would accept every bounce as a press
  if (CNT_MAX < 1)
  begin : g_bad
    $error("brc_debounce: CNT_MAX must be at least 1");
  end

  // Level must stay differing for CNT_MAX cycles before it is taken
  always_comb
  begin
    r_d = r_q;
    r_d.s1 = !button_n_in;
    r_d.s2 = r_q.s1;
    if (r_q.s2 == r_q.pressed)
    begin
      r_d.cnt = '0;
    end
    else if (r_q.cnt == CW'(CNT_MAX - 1))
    begin
      r_d.pressed = r_q.s2;
      r_d.cnt = '0;
    end
    else
    begin
      r_d.cnt = r_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      r_q <= '{s1: 1'b0, s2: 1'b0, pressed: 1'b0, cnt: '0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign pressed_out = r_q.pressed;

endmodule : brc_debounce

// >>> core/brc_top.sv
// Board reset, reset configuration, abort routing and clock steering
// How it works
// - Soft button alone drives soft reset line
// - Both buttons together drive hard reset line
// - Reset lines only pulled low, open drain
// - Power-on, 1:5 mode: clock-mode pins high
// - Power-on, 1:513 mode: clock-mode pins low
// - Config strobe asserted throughout every hard reset
// - Config word drives data bits during strobe
// - Defaults at power-on; writes apply next hard
// - Default: internal arb, prefix zero, boot, 32-bit
// - Default: base FF00000, PCMCIA B, JTAG debug
// - Abort button alone pulls interrupt line zero low
// - 1:513 mode gates clock, input held zero
// - Logic clock follows processor or debug clock
module brc_top
  import brc_pkg::*;
#(
  parameter int DEBOUNCE_CNT = DEBOUNCE_CYC
)(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  // Classic Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Push-buttons, low while pressed
  input wire logic abort_button_n_in,
  input wire logic soft_reset_button_n_in,
  // Board pins
  input wire logic power_on_reset_line_n_in,
  input wire logic clock_select_dip_in,
  input wire logic processor_present_in,
  input wire logic hard_reset_line_n_in,
  output logic hard_reset_line_n_out,
  output logic hard_reset_line_oe_n_out,
  input wire logic soft_reset_line_n_in,
  output logic soft_reset_line_n_out,
  output logic soft_reset_line_oe_n_out,
  output logic interrupt_line_zero_n_out,
  output logic interrupt_line_zero_oe_n_out,
  output logic [1:0] clock_mode_select_out,
  output logic clock_mode_select_oe_n_out,
  output logic reset_config_strobe_n_out,
  output logic [15:0] config_data_out,
  output logic config_data_oe_n_out,
  output logic osc_gate_out,
  output logic logic_clk_sel_out
);

  brc_regs_t r_q;
  brc_regs_t r_d;
  logic abort_pressed;
  logic soft_pressed;
  logic both;
  logic por_on;
  logic hline_low;
  logic mode513;
  logic drive_hard;
  logic bus_req;

  // A hold counter too narrow would never reach the least hold time
  if (MIN_HOLD_CYC >= (1 << HOLD_W))
  begin : g_bad
    $error("brc_top: HOLD_W too small for MIN_HOLD_CYC");
  end

  // Button inputs pass synchroniser and debounce first
  brc_debounce #(
    .CNT_MAX(DEBOUNCE_CNT)
  ) u_abort_deb (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .button_n_in(abort_button_n_in),
    .pressed_out(abort_pressed)
  );

  brc_debounce #(
    .CNT_MAX(DEBOUNCE_CNT)
  ) u_soft_deb (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .button_n_in(soft_reset_button_n_in),
    .pressed_out(soft_pressed)
  );

  // Decoded views of the synchronised pins
  assign both = abort_pressed && soft_pressed;
  assign por_on = !r_q.s2[PIN_POR_N];
  assign hline_low = !r_q.s2[PIN_HARD_N];
  assign mode513 = r_q.s2[PIN_DIP];
  assign bus_req = wb_cyc_in && wb_stb_in && !r_q.ack;

  // Next-state logic for the whole block
  always_comb
  begin
    r_d = r_q;
    drive_hard = 1'b0;
    // Two-stage synchroniser for every asynchronous pin
    r_d.s1[PIN_POR_N] = power_on_reset_line_n_in;
    r_d.s1[PIN_DIP] = clock_select_dip_in;
    r_d.s1[PIN_PROC] = processor_present_in;
    r_d.s1[PIN_HARD_N] = hard_reset_line_n_in;
    r_d.s1[PIN_SOFT_N] = soft_reset_line_n_in;
    r_d.s2 = r_q.s1;

    // Button sequencer; the hold counter saturates
    if (r_q.cnt != '1)
    begin
      r_d.cnt = r_q.cnt + 1'b1;
    end
    case (r_q.st)
      ST_IDLE:
      begin
        if (both)
        begin
          r_d.st = ST_HARD;
          r_d.cnt = '0;
        end
        else if (soft_pressed)
        begin
          r_d.st = ST_SOFT;
          r_d.cnt = '0;
        end
      end
      ST_SOFT:
      begin
        // A late abort press upgrades to a hard reset
        if (both)
        begin
          r_d.st = ST_HARD;
          r_d.cnt = '0;
        end
        else if (!soft_pressed && r_q.cnt >= HOLD_W'(MIN_HOLD_CYC - 1))
        begin
          r_d.st = ST_WAIT;
        end
      end
      ST_HARD:
      begin
        // Same least hold as the processor's own sources
        if (!both && r_q.cnt >= HOLD_W'(MIN_HOLD_CYC - 1))
        begin
          r_d.st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // No new action until both buttons are let go
        if (!abort_pressed && !soft_pressed)
        begin
          r_d.st = ST_IDLE;
        end
      end
      default:
      begin
        r_d.st = ST_IDLE;
      end
    endcase
    // Power-on overrides the buttons
    if (por_on)
    begin
      r_d.st = ST_IDLE;
      r_d.cnt = '0;
    end

    // Open-drain drives: level fixed low, only enables move
    r_d.od_lvl = 1'b0;
    drive_hard = por_on || (r_d.st == ST_HARD);
    r_d.hard_oe_n = !drive_hard;
    r_d.soft_oe_n = !(r_d.st == ST_SOFT);
    // Abort alone raises the interrupt, only while the sequencer is in ST_IDLE
    r_d.irq_oe_n = !(abort_pressed && !soft_pressed
                     && r_d.st == ST_IDLE);

    // Strobe covers board and processor hard resets alike
    r_d.in_hard = hline_low || drive_hard;
    r_d.conf_n = !r_d.in_hard;
    r_d.dat_oe_n = !r_d.in_hard;
    // Written word becomes active as a hard reset begins
    if (r_d.in_hard && !r_q.in_hard)
    begin
      r_d.cfg_act = r_q.cfg_next;
    end

    // Clock-mode pins follow the switch during power-on
    if (por_on)
    begin
      r_d.modck = mode513 ? MODCK_PLL513 : MODCK_PLL5;
      r_d.modck_oe_n = 1'b0;
    end
    else if (!r_d.in_hard)
    begin
      // Held on through the hard reset so they stay stable
      r_d.modck_oe_n = 1'b1;
    end

    // Oscillator cut off the clock input in crystal mode
    r_d.gate = !mode513;
    // Logic clock source: processor when fitted, else debug port
    r_d.clk_sel = r_q.s2[PIN_PROC];

    // Wishbone slave: one-cycle ack, unmapped reads zero
    r_d.ack = bus_req;
    r_d.rdat = '0;
    if (bus_req)
    begin
      case (wb_adr_in)
        REG_CFG_NEXT:
        begin
          r_d.rdat = {16'h0000, r_q.cfg_next};
          if (wb_we_in && wb_sel_in[0])
          begin
            r_d.cfg_next[7:0] = wb_dat_in[7:0];
          end
          if (wb_we_in && wb_sel_in[1])
          begin
            r_d.cfg_next[15:8] = wb_dat_in[15:8];
          end
        end
        REG_CFG_ACT:
        begin
          r_d.rdat = {16'h0000, r_q.cfg_act};
        end
        REG_STATUS:
        begin
          r_d.rdat[STS_STATE_LSB +: 2] = r_q.st;
          r_d.rdat[STS_HARD_BIT] = hline_low;
          r_d.rdat[STS_SOFT_BIT] = !r_q.s2[PIN_SOFT_N];
          r_d.rdat[STS_POR_BIT] = por_on;
          r_d.rdat[STS_DIP_BIT] = mode513;
          r_d.rdat[STS_PROC_BIT] = r_q.s2[PIN_PROC];
        end
        default:
        begin
          r_d.rdat = '0;
        end
      endcase
    end

    // Power-on reloads defaults, beating any write
    if (por_on)
    begin
      r_d.cfg_next = CFG_DEFAULT;
      r_d.cfg_act = CFG_DEFAULT;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      r_q <= BRC_REGS_RST;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_out = r_q.rdat;
  assign wb_ack_out = r_q.ack;
  assign hard_reset_line_n_out = r_q.od_lvl;
  assign hard_reset_line_oe_n_out = r_q.hard_oe_n;
  assign soft_reset_line_n_out = r_q.od_lvl;
  assign soft_reset_line_oe_n_out = r_q.soft_oe_n;
  assign interrupt_line_zero_n_out = r_q.od_lvl;
  assign interrupt_line_zero_oe_n_out = r_q.irq_oe_n;
  assign clock_mode_select_out = r_q.modck;
  assign clock_mode_select_oe_n_out = r_q.modck_oe_n;
  assign reset_config_strobe_n_out = r_q.conf_n;
  assign config_data_out = r_q.cfg_act;
  assign config_data_oe_n_out = r_q.dat_oe_n;
  assign osc_gate_out = r_q.gate;
  assign logic_clk_sel_out = r_q.clk_sel;

  // Soft button alone starts a soft reset next edge
  chk_soft_alone: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (r_q.st == ST_IDLE && soft_pressed && !abort_pressed && !por_on)
    |=> !soft_reset_line_oe_n_out && hard_reset_line_oe_n_out)
    else $error("soft button did not start soft reset");

  // Both buttons start a hard reset next edge
  chk_hard_both: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (r_q.st != ST_WAIT && both)
    |=> !hard_reset_line_oe_n_out && soft_reset_line_oe_n_out)
    else $error("button pair did not start hard reset");

  // Driven level is always low on the open-drain reset lines
  chk_od_level: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !hard_reset_line_oe_n_out || !soft_reset_line_oe_n_out
    |-> !hard_reset_line_n_out && !soft_reset_line_n_out)
    else $error("open-drain pin driven high");

  // Board hard reset is held at least eight cycles once begun
  chk_hard_hold: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    $fell(hard_reset_line_oe_n_out) && !por_on
    |-> !hard_reset_line_oe_n_out [*8])
    else $error("hard reset released too early");

  // Clock-mode pins match the switch during power-on
  chk_modck_por: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    por_on ##1 por_on |-> !clock_mode_select_oe_n_out
    && clock_mode_select_out == ($past(mode513) ? MODCK_PLL513
                                 : MODCK_PLL5))
    else $error("clock-mode pins wrong during power-on");

  // Strobe follows the sensed hard reset line
  chk_strobe_hard: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    hline_low |=> !reset_config_strobe_n_out && !config_data_oe_n_out)
    else $error("strobe missing during hard reset");

  // Active word moves only as a hard reset begins
  chk_cfg_stable: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    !r_d.in_hard && !por_on |=> $stable(config_data_out))
    else $error("config word changed outside hard reset");

  // Power-on leaves the default word active
  chk_cfg_default: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    por_on |=> config_data_out == CFG_DEFAULT)
    else $error("config default not loaded at power-on");

  // Abort alone pulls the interrupt line
  chk_abort_irq: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    (r_q.st == ST_IDLE && abort_pressed && !soft_pressed && !por_on)
    |=> !interrupt_line_zero_oe_n_out)
    else $error("abort did not raise interrupt");

  // Crystal mode gates the oscillator next edge
  chk_osc_gate: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    mode513 |=> !osc_gate_out)
    else $error("oscillator not gated in crystal mode");

endmodule : brc_top

// >>> verif/brc_proc_model.sv
// Processor-side model of the open-drain reset and interrupt wires
module brc_proc_model
  import brc_pkg::*;
#(
  parameter bit DBG_ENABLE = 1'b1,
  parameter bit DBG_ENTER_NOW = 1'b1,
  parameter bit DBG_CLK_MODE = 1'b0
)(
  input wire logic clk_in,
  input wire logic hard_oe_n_in,
  input wire logic soft_oe_n_in,
  input wire logic irq_oe_n_in,
  input wire logic int_reset_in,
  output logic hard_n_out,
  output logic soft_n_out,
  output logic irq_n_out,
  output logic debug_serial_clock_out,
  output logic debug_serial_in_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] hold_q = '0;
  // Internal source keeps the hard line low for the least hold time
  always @(posedge clk_in)
  begin
    if (int_reset_in && hold_q == '0)
      hold_q <= 10'(MIN_HOLD_CYC - 1);
    else if (hold_q != '0)
      hold_q <= hold_q - 10'h001;
  end
  // Pulled-up wires: released means high, any party may pull low
  assign hard_n_out = hard_oe_n_in & (hold_q == '0) & !int_reset_in;
  assign soft_n_out = soft_oe_n_in;
  // Off-board interrupt source stays released, open drain only
  assign irq_n_out = irq_oe_n_in;
  // Debug controller: enable level while soft reset runs, then entry
  // level, immediate or only after an exception
  assign debug_serial_clock_out = soft_n_out ? (DBG_ENABLE && DBG_ENTER_NOW)
                                             : DBG_ENABLE;
  // Debug clock mode shown on data-in once soft reset ends
  assign debug_serial_in_out = soft_n_out ? DBG_CLK_MODE : 1'b0;
endmodule : brc_proc_model

// >>> verif/board_reset_config_logic_tb.sv
// Self-checking bench for the board reset and configuration logic
module board_reset_config_logic_tb
  import brc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [3:0] wb_adr_in, wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rng_q, x;
  logic wb_ack_out, abort_n, soft_n, por_n, dip, present, int_rst;
  logic hard_wire_n, soft_wire_n, irq_wire_n, hard_drv, soft_drv, irq_drv;
  logic hard_oe_n, soft_oe_n, irq_oe_n, modck_oe_n, strobe_n, data_oe_n;
  logic osc_gate, clk_sel, dbg_clk, dbg_in;
  logic [1:0] modck;
  logic [15:0] cfg_data, cfg;
  logic [31:0] rd_q[$];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;

  brc_top #(.DEBOUNCE_CNT(4)) i_brc_top (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .abort_button_n_in(abort_n), .soft_reset_button_n_in(soft_n),
    .power_on_reset_line_n_in(por_n), .clock_select_dip_in(dip),
    .processor_present_in(present), .hard_reset_line_n_in(hard_wire_n),
    .hard_reset_line_n_out(hard_drv), .hard_reset_line_oe_n_out(hard_oe_n),
    .soft_reset_line_n_in(soft_wire_n), .soft_reset_line_n_out(soft_drv),
    .soft_reset_line_oe_n_out(soft_oe_n),
    .interrupt_line_zero_n_out(irq_drv),
    .interrupt_line_zero_oe_n_out(irq_oe_n),
    .clock_mode_select_out(modck), .clock_mode_select_oe_n_out(modck_oe_n),
    .reset_config_strobe_n_out(strobe_n), .config_data_out(cfg_data),
    .config_data_oe_n_out(data_oe_n), .osc_gate_out(osc_gate),
    .logic_clk_sel_out(clk_sel));

  brc_proc_model i_brc_proc_model (
    .clk_in(ref_clk_in), .hard_oe_n_in(hard_oe_n), .soft_oe_n_in(soft_oe_n),
    .irq_oe_n_in(irq_oe_n), .int_reset_in(int_rst),
    .hard_n_out(hard_wire_n), .soft_n_out(soft_wire_n),
    .irq_n_out(irq_wire_n), .debug_serial_clock_out(dbg_clk),
    .debug_serial_in_out(dbg_in));

  always #50 ref_clk_in = ~ref_clk_in;

  task automatic chk_word(input string what, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", what, e, g);
      err_total++;
    end
  endtask : chk_word

  task automatic chk_pin(input string what, input logic [15:0] e,
    input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", what, e, g);
      err_total++;
    end
  endtask : chk_pin

  task automatic print_verdict;
    $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift

  // Classic cycle: hold the request until ack is sampled, then idle
  // No wait of its own: only the hang guard ends a missing answer
  task automatic bus(input logic [3:0] a, input logic we,
    input logic [31:0] d, input logic [3:0] s = 4'hf);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_sel_in <= s;
    wb_dat_in <= d;
    @(posedge ref_clk_in);
    while (wb_ack_out !== 1'b1)
    begin
      @(posedge ref_clk_in);
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  function automatic logic pin(input int s);
    case (s)
      0: return hard_oe_n;
      1: return soft_oe_n;
      default: return irq_oe_n;
    endcase
  endfunction : pin

  // Wait for a pull-down enable to reach a level; hang guard bounds it
  task automatic wait_pin(input int s, input logic lvl, output int c);
    c = 0;
    while (pin(s) !== lvl)
    begin
      @(posedge ref_clk_in);
      c++;
    end
  endtask : wait_pin

  // Watcher takes the oldest expected read at each read ack
  always @(posedge ref_clk_in)
  begin
    if (wb_ack_out && wb_cyc_in && !wb_we_in && rd_q.size() > 0)
      chk_word("read data", rd_q.pop_front(), wb_dat_out);
  end

  // Hang guard: the whole run needs a few thousand cycles
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    ref_clk_in = 1'b0;
    srst_in = 1'b1;
    {wb_cyc_in, wb_stb_in, wb_we_in, int_rst, dip, por_n} = '0;
    {wb_adr_in, wb_sel_in, wb_dat_in} = '0;
    {abort_n, soft_n, present} = 3'h7;
    rng_q = 32'h0000_003d;
    repeat (8) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    // Power-on: mode pins follow the switch, oscillator gated in 1:513
    chk_pin("mode 1:5", 16'h0003, {14'h0, modck});
    chk_pin("mode driven", 16'h0, {15'h0, modck_oe_n});
    dip <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    chk_pin("mode 1:513", 16'h0, {14'h0, modck});
    chk_pin("osc gated", 16'h0, {15'h0, osc_gate});
    dip <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    chk_pin("osc passes", 16'h1, {15'h0, osc_gate});
    por_n <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    chk_pin("mode held", 16'h0003, {14'h0, modck});
    chk_pin("mode still driven", 16'h0, {15'h0, modck_oe_n});
    wait_pin(0, 1'b1, n);
    // Defaults, unmapped and read-only places, then a random next word
    rd(4'h4, 32'h0000_0200);
    rd(4'h0, 32'h0000_0200);
    rd(4'hc, 32'h0);
    rd(4'h8, 32'h0000_0040);
    rng_q = xorshift(rng_q);
    x = rng_q;
    cfg = x[15:0];
    bus(4'h0, 1'b1, x);
    bus(4'h4, 1'b1, ~x);
    rd(4'h0, {16'h0, cfg});
    rd(4'h4, 32'h0000_0200);
    // Upper byte lane alone
    bus(4'h0, 1'b1, ~x, 4'h2);
    cfg[15:8] = ~x[15:8];
    rd(4'h0, {16'h0, cfg});
    // Soft button alone: soft line only, held the least time
    soft_n <= 1'b0;
    wait_pin(1, 1'b0, n);
    chk_pin("hard idle", 16'h1, {15'h0, hard_oe_n});
    chk_pin("dbg enable", 16'h1, {15'h0, dbg_clk});
    chk_pin("drive value", 16'h0, {14'h0, soft_drv, hard_drv});
    soft_n <= 1'b1;
    wait_pin(1, 1'b1, n);
    chk_pin("soft hold", 16'h1, {15'h0, n >= MIN_HOLD_CYC - 1});
    chk_pin("dbg entry", 16'h1, {15'h0, dbg_clk});
    chk_pin("dbg clk mode", 16'h0, {15'h0, dbg_in});
    repeat (20) @(posedge ref_clk_in);
    // Abort alone: interrupt pulled low while held
    abort_n <= 1'b0;
    wait_pin(2, 1'b0, n);
    chk_pin("irq drive", 16'h0, {15'h0, irq_drv});
    chk_pin("irq wire", 16'h0, {15'h0, irq_wire_n});
    chk_pin("no soft", 16'h1, {15'h0, soft_oe_n});
    abort_n <= 1'b1;
    wait_pin(2, 1'b1, n);
    repeat (20) @(posedge ref_clk_in);
    // Both buttons: hard reset with the written word on the data bus
    abort_n <= 1'b0;
    soft_n <= 1'b0;
    wait_pin(0, 1'b0, n);
    repeat (2) @(posedge ref_clk_in);
    chk_pin("strobe", 16'h0, {15'h0, strobe_n});
    chk_pin("data oe", 16'h0, {15'h0, data_oe_n});
    chk_pin("config word", cfg, cfg_data);
    rd(4'h8, 32'h0000_0047);
    abort_n <= 1'b1;
    soft_n <= 1'b1;
    wait_pin(0, 1'b1, n);
    repeat (4) @(posedge ref_clk_in);
    rd(4'h4, {16'h0, cfg});
    // Logic clock steering follows processor presence
    chk_pin("clk sel", 16'h1, {15'h0, clk_sel});
    present <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    chk_pin("clk sel", 16'h0, {15'h0, clk_sel});
    present <= 1'b1;
    // Processor internal hard reset also gets the strobe
    int_rst <= 1'b1;
    @(posedge ref_clk_in);
    int_rst <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    chk_pin("int strobe", 16'h0, {15'h0, strobe_n});
    chk_pin("int word", cfg, cfg_data);
    repeat (600) @(posedge ref_clk_in);
    chk_pin("strobe end", 16'h1, {15'h0, strobe_n});
    print_verdict();
  end
endmodule : board_reset_config_logic_tb
